// ---- rtl/swp_pkg.sv ----
// Shared constants, types and helpers of the switch port datapath.
// Assumes one clock and the switch engine bus on the far side.
package swp_pkg;
  localparam int NUM_NET = 26;
  localparam int FIRST_FAST = 24;
  localparam int HOST_PORT = 26;
  localparam int SE_PORT = 27;
  localparam int AW = 24;
  localparam int WCW = 10;
  localparam int QCW = 8;
  localparam int RXD_SLOW = 32;
  localparam int RXD_FAST = 128;
  localparam int TXD_SLOW = 64;
  localparam int TXD_FAST = 128;
  localparam int TXQ_DEPTH = 128;
  localparam int TXQ_W = 24;
  localparam int LK_BYTES = 12;
  localparam int RUNT_BYTES = 64;
  localparam int CT_CHUNK = 8;
  localparam int HDR_WORDS = 2;
  localparam int H1_SRC_LSB = 27;
  localparam int H2_ID_LSB = 26;
  localparam int H2_ERR = 25;
  localparam int H2_RUNT = 23;
  localparam int H2_FRM = 21;
  localparam int H2_CRC = 20;
  localparam int H2_BC = 19;
  localparam int H2_MC = 18;
  localparam int H2_OVF = 16;
  localparam int H2_WC_LSB = 2;
  localparam int H2_WC_MSB = 11;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic ct_en;
  } swp_ctl_t;

  typedef struct packed {
    swp_ctl_t port_control_word_zero;
    logic [AW-1:0] buffer_start_address_reg;
    logic [AW-1:0] buffer_end_address_reg;
    logic [QCW-1:0] hwm;
  } swp_cfg_t;

  typedef struct packed {
    logic last;
    logic crc_err;
    logic frame_err;
    logic [7:0] data;
  } swp_rx_byte_t;

  typedef struct packed {
    logic wr;
    logic [AW-1:0] addr;
    logic [WCW-1:0] cnt;
  } swp_burst_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'h0, B_REQ = 2'h1, B_XFER = 2'h3, B_DONE = 2'h2
  } swp_bus_st_t;

  typedef enum logic [1:0] {
    J_RXD = 2'h0, J_HDR = 2'h1, J_TXH = 2'h3, J_TXD = 2'h2
  } swp_job_t;

  // Burst length capped by two limits and by the buffer end
  function automatic logic [WCW-1:0] swp_span(input logic [AW-1:0] p,
      input logic [AW-1:0] e, input logic [WCW-1:0] a,
      input logic [WCW-1:0] b);
    logic [AW-1:0] room;
    logic [WCW-1:0] r;
    room = AW'(e - p + AW'(1));
    r = (a < b) ? a : b;
    if (room < AW'(r)) r = room[WCW-1:0];
    return r;
  endfunction

  // Advance a pointer inside the circular buffer
  function automatic logic [AW-1:0] swp_adv(input logic [AW-1:0] p,
      input logic [WCW-1:0] n, input logic [AW-1:0] s,
      input logic [AW-1:0] e);
    logic [AW-1:0] room;
    room = AW'(e - p);
    if (AW'(n) > room) return AW'(s + AW'(n) - room - AW'(1));
    return AW'(p + AW'(n));
  endfunction
endpackage

// ---- rtl/swp_fifo.sv ----
// Flip-flop FIFO with combinational head word.
// Ignores a push when full and a pop when empty.
`timescale 1ns/1ps
module swp_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input logic ref_clk,
  input logic srst,
  // Write side
  input logic push,
  input logic [W-1:0] wdata,
  // Read side
  input logic pop,
  output logic [W-1:0] head,
  // Status
  output logic full,
  output logic empty,
  output logic [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q;
  logic do_push, do_pop;

  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = cnt_q == CW'(DEPTH);
  assign empty = cnt_q == '0;
  assign count = cnt_q;
  assign head = mem_q[rp_q];

  always_ff @(posedge ref_clk) begin
    if (do_push) mem_q[wp_q] <= wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : PW'(wp_q + 1'b1);
      if (do_pop) rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : PW'(rp_q + 1'b1);
      cnt_q <= CW'(cnt_q + CW'(do_push) - CW'(do_pop));
    end
  end
endmodule // swp_fifo

// ---- rtl/swp_port_datapath.sv ----
// One network port: receive packing, packet buffer writes, header,
// transmit queue, reads back to the MAC and backpressure.
// Assumes MAC, lookup and memory control run on ref_clk.
//
// How it works
// - Ports 0-23 slow, 24-25 fast, 26 host
// - Pseudo-port 27 never appears as destination
// - Cut-through only on slow ports
// - Separate receive and transmit enable bits
// - Buffer written sequentially, wraps to start
// - Host-bound packets stay in this buffer
// - Start and end registers bound the buffer
// - Configuration is live, never latched
// - Rx FIFO 32 wide, 32 or 128 deep
// - Bytes packed into 32-bit words
// - Controller issues bus, lookup requests, addresses
// - Header built at end, carries errors
// - Tx FIFO 32 wide, 64 or 128 deep
// - Pointer queue 128 entries of 24 bits
// - Tx reads packets into Tx FIFO
// - Queue above high-water mark raises backpressure
// - Address and count set before burst
// - Memory control runs burst on request
// - Each prompt moves one word
// - Only memory control touches the SDRAM
// - Word one: source port and destination bitmap
// - Header is last two words on bus
// - Word two carries buffer word count
`timescale 1ns/1ps
module swp_port_datapath import swp_pkg::*; #(
  parameter int PORT_NUM = 0,
  parameter int RX_DEPTH = (PORT_NUM >= FIRST_FAST) ? RXD_FAST : RXD_SLOW,
  parameter int TX_DEPTH = (PORT_NUM >= FIRST_FAST) ? TXD_FAST : TXD_SLOW,
  parameter int TXQ_D = TXQ_DEPTH
) (
  // Clock and reset
  input logic ref_clk,
  input logic srst,
  // Port configuration
  input swp_cfg_t cfg,
  // Receive bytes from MAC
  input logic rx_valid,
  input swp_rx_byte_t rx_byte,
  // Lookup
  output logic lk_req_q,
  input logic lk_done,
  input logic [HOST_PORT:0] lk_dst,
  input logic lk_bcast,
  input logic lk_mcast,
  // Switching bus to memory control
  output logic bus_req_q,
  input logic bus_gnt,
  output swp_burst_t mc_burst_q,
  input logic mc_prompt,
  output logic [31:0] bus_wdata_q,
  input logic [31:0] bus_rdata,
  // Transmit pointer queue load
  input logic txq_push,
  input logic [TXQ_W-1:0] txq_ptr,
  // Transmit words to MAC
  output logic mac_tx_valid_q,
  output logic [31:0] mac_tx_data_q,
  input logic mac_tx_ready,
  // Flow control
  output logic bp_q
);
  localparam bit FAST = PORT_NUM >= FIRST_FAST;
  localparam int RCW = $clog2(RX_DEPTH) + 1;
  localparam int TCW = $clog2(TX_DEPTH) + 1;
  localparam int QW = $clog2(TXQ_D) + 1;

  ////////////////////////////////////////////////////////////////////
  // Live configuration
  logic [AW-1:0] b_lo, b_hi;
  logic ct_mode;
  assign b_lo = cfg.buffer_start_address_reg;
  assign b_hi = cfg.buffer_end_address_reg;
  assign ct_mode = !FAST && cfg.port_control_word_zero.ct_en;

  ////////////////////////////////////////////////////////////////////
  // Receive packing
  logic rx_act_q, drop_q, hdr_pend_q;
  logic [1:0] bcnt_q;
  logic [31:0] pack_q, word_c;
  logic [15:0] nbytes_q;
  logic [WCW-1:0] nwords_q;
  logic crc_q, frm_q, ovf_q;
  logic take, rx_push, rx_pop, rx_full, rx_empty;
  logic [31:0] rx_head;
  logic [RCW-1:0] rx_cnt;

  assign take = rx_valid && !drop_q && cfg.port_control_word_zero.rx_en
    && (rx_act_q || !hdr_pend_q);
  assign rx_push = take && (bcnt_q == 2'h3 || rx_byte.last);

  always_comb begin
    word_c = pack_q;
    word_c[bcnt_q*8 +: 8] = rx_byte.data;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_act_q <= 1'b0;
      drop_q <= 1'b0;
      bcnt_q <= '0;
      pack_q <= 32'h0000_0000;
      nbytes_q <= '0;
      nwords_q <= '0;
      crc_q <= 1'b0;
      frm_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (rx_valid && !take && !rx_act_q) drop_q <= !rx_byte.last;
      if (drop_q && rx_valid && rx_byte.last) drop_q <= 1'b0;
      if (take) begin
        if (!rx_act_q) begin
          nbytes_q <= 16'h0001;
          nwords_q <= '0;
          crc_q <= 1'b0;
          frm_q <= 1'b0;
          ovf_q <= 1'b0;
        end else begin
          nbytes_q <= 16'(nbytes_q + 1'b1);
        end
        rx_act_q <= !rx_byte.last;
        bcnt_q <= rx_byte.last ? 2'h0 : 2'(bcnt_q + 1'b1);
        pack_q <= rx_push ? 32'h0000_0000 : word_c;
        if (rx_byte.last) begin
          crc_q <= rx_byte.crc_err;
          frm_q <= rx_byte.frame_err;
        end
        if (rx_push && rx_full) ovf_q <= 1'b1;
        if (rx_push && !rx_full) nwords_q <= WCW'(nwords_q + 1'b1);
      end
    end
  end

  swp_fifo #(.W(32), .DEPTH(RX_DEPTH)) u_rxf (
    .ref_clk(ref_clk), .srst(srst), .push(rx_push), .wdata(word_c),
    .pop(rx_pop), .head(rx_head), .full(rx_full), .empty(rx_empty),
    .count(rx_cnt));

  ////////////////////////////////////////////////////////////////////
  // Lookup request and result
  logic lk_sent_q, lk_got_q, bc_q, mc_q;
  logic [HOST_PORT:0] dst_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lk_req_q <= 1'b0;
      lk_sent_q <= 1'b0;
      lk_got_q <= 1'b0;
      dst_q <= '0;
      bc_q <= 1'b0;
      mc_q <= 1'b0;
    end else begin
      lk_req_q <= 1'b0;
      if (take && !rx_act_q) begin
        lk_sent_q <= 1'b0;
        lk_got_q <= 1'b0;
      end
      if (take && !lk_sent_q && rx_act_q
          && (nbytes_q == 16'(LK_BYTES - 1) || rx_byte.last)) begin
        lk_req_q <= 1'b1;
        lk_sent_q <= 1'b1;
      end
      if (lk_done && lk_sent_q && !lk_got_q) begin
        lk_got_q <= 1'b1;
        dst_q <= lk_dst;
        bc_q <= lk_bcast;
        mc_q <= lk_mcast;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Header words
  logic [5:0] pkt_id_q;
  logic [31:0] hdr1, hdr2;

  always_comb begin
    hdr1 = 32'h0000_0000;
    hdr1[H1_SRC_LSB +: 5] = 5'(PORT_NUM);
    hdr1[HOST_PORT:0] = dst_q;
    hdr2 = 32'h0000_0000;
    hdr2[H2_ID_LSB +: 6] = pkt_id_q;
    hdr2[H2_RUNT] = nbytes_q < 16'(RUNT_BYTES);
    hdr2[H2_FRM] = frm_q;
    hdr2[H2_CRC] = crc_q;
    hdr2[H2_OVF] = ovf_q;
    hdr2[H2_ERR] = hdr2[H2_RUNT] | frm_q | crc_q | ovf_q;
    hdr2[H2_BC] = bc_q;
    hdr2[H2_MC] = mc_q;
    hdr2[H2_WC_MSB:H2_WC_LSB] = nwords_q;
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit queue and FIFO
  logic txq_full, txq_empty, txq_pop;
  logic [TXQ_W-1:0] txq_head;
  logic [QW-1:0] txq_cnt;
  logic txf_push, txf_pop, txf_full, txf_empty;
  logic [31:0] txf_head;
  logic [TCW-1:0] txf_cnt;
  logic [WCW-1:0] txf_free;

  swp_fifo #(.W(TXQ_W), .DEPTH(TXQ_D)) u_txq (
    .ref_clk(ref_clk), .srst(srst), .push(txq_push), .wdata(txq_ptr),
    .pop(txq_pop), .head(txq_head), .full(txq_full), .empty(txq_empty),
    .count(txq_cnt));

  swp_fifo #(.W(32), .DEPTH(TX_DEPTH)) u_txf (
    .ref_clk(ref_clk), .srst(srst), .push(txf_push), .wdata(bus_rdata),
    .pop(txf_pop), .head(txf_head), .full(txf_full), .empty(txf_empty),
    .count(txf_cnt));
  assign txf_free = WCW'(TX_DEPTH) - WCW'(txf_cnt);

  ////////////////////////////////////////////////////////////////////
  // Bus sequencer
  swp_bus_st_t st_q;
  swp_job_t job_q;
  logic [WCW-1:0] beat_q, tx_left_q;
  logic [AW-1:0] rx_base_q, rx_wptr_q, tx_ptr_q;
  logic tx_busy_q, rxd_go, hdr_go, txh_go, txd_go, beat;
  logic [AW-1:0] pkt_base;

  // Header pair never straddles the buffer end
  assign pkt_base = (rx_wptr_q < b_lo || rx_wptr_q >= b_hi) ? b_lo : rx_wptr_q;

  assign hdr_go = cfg.port_control_word_zero.rx_en && hdr_pend_q
    && rx_empty && lk_got_q;
  assign rxd_go = cfg.port_control_word_zero.rx_en && !rx_empty
    && (hdr_pend_q || (ct_mode && rx_cnt >= RCW'(CT_CHUNK)));
  assign txd_go = cfg.port_control_word_zero.tx_en && tx_busy_q
    && tx_left_q != '0 && txf_free != '0;
  assign txh_go = cfg.port_control_word_zero.tx_en && !tx_busy_q
    && !txq_empty;
  assign beat = st_q == B_XFER && mc_prompt;
  assign rx_pop = beat && job_q == J_RXD;
  assign txf_push = beat && job_q == J_TXD;
  assign txq_pop = st_q == B_DONE && job_q == J_TXH;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= B_IDLE;
      job_q <= J_RXD;
      bus_req_q <= 1'b0;
      mc_burst_q <= '0;
      beat_q <= '0;
    end else begin
      case (st_q)
        B_IDLE: begin
          st_q <= B_REQ;
          bus_req_q <= 1'b1;
          if (hdr_go) begin
            job_q <= J_HDR;
            mc_burst_q <= '{1'b1, rx_base_q, WCW'(HDR_WORDS)};
          end else if (rxd_go) begin
            job_q <= J_RXD;
            mc_burst_q <= '{1'b1, rx_wptr_q,
              swp_span(rx_wptr_q, b_hi, WCW'(rx_cnt), WCW'(rx_cnt))};
          end else if (txd_go) begin
            job_q <= J_TXD;
            mc_burst_q <= '{1'b0, tx_ptr_q,
              swp_span(tx_ptr_q, b_hi, tx_left_q, txf_free)};
          end else if (txh_go) begin
            job_q <= J_TXH;
            mc_burst_q <= '{1'b0, txq_head, WCW'(HDR_WORDS)};
          end else begin
            st_q <= B_IDLE;
            bus_req_q <= 1'b0;
          end
        end
        B_REQ: begin
          beat_q <= '0;
          if (bus_gnt) st_q <= B_XFER;
        end
        B_XFER: begin
          if (mc_prompt) begin
            beat_q <= WCW'(beat_q + 1'b1);
            if (beat_q == WCW'(mc_burst_q.cnt - 1'b1)) begin
              st_q <= B_DONE;
              bus_req_q <= 1'b0;
            end
          end
        end
        B_DONE: st_q <= B_IDLE;
        default: st_q <= B_IDLE;
      endcase
    end
  end

  // Write data and pointer bookkeeping
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_wdata_q <= 32'h0000_0000;
      hdr_pend_q <= 1'b0;
      pkt_id_q <= '0;
      rx_base_q <= '0;
      rx_wptr_q <= '0;
      tx_busy_q <= 1'b0;
      tx_left_q <= '0;
      tx_ptr_q <= '0;
    end else begin
      if (beat && job_q == J_RXD) bus_wdata_q <= rx_head;
      if (beat && job_q == J_HDR) bus_wdata_q <= (beat_q == '0) ? hdr1 : hdr2;
      if (take && !rx_act_q) begin
        rx_base_q <= pkt_base;
        rx_wptr_q <= swp_adv(pkt_base, WCW'(HDR_WORDS), b_lo, b_hi);
      end
      if (take && rx_byte.last) hdr_pend_q <= 1'b1;
      if (beat && job_q == J_TXH && beat_q == WCW'(1))
        tx_left_q <= bus_rdata[H2_WC_MSB:H2_WC_LSB];
      if (st_q == B_DONE) begin
        case (job_q)
          J_HDR: begin
            hdr_pend_q <= 1'b0;
            pkt_id_q <= 6'(pkt_id_q + 1'b1);
          end
          J_RXD: rx_wptr_q <= swp_adv(rx_wptr_q, mc_burst_q.cnt, b_lo, b_hi);
          J_TXH: begin
            tx_busy_q <= 1'b1;
            tx_ptr_q <= swp_adv(mc_burst_q.addr, WCW'(HDR_WORDS), b_lo, b_hi);
          end
          J_TXD: begin
            tx_left_q <= WCW'(tx_left_q - mc_burst_q.cnt);
            tx_ptr_q <= swp_adv(tx_ptr_q, mc_burst_q.cnt, b_lo, b_hi);
          end
          default: hdr_pend_q <= hdr_pend_q;
        endcase
      end
      if (tx_busy_q && tx_left_q == '0 && st_q == B_IDLE) tx_busy_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // MAC output stage and backpressure
  assign txf_pop = cfg.port_control_word_zero.tx_en && !txf_empty
    && (!mac_tx_valid_q || mac_tx_ready);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mac_tx_valid_q <= 1'b0;
      mac_tx_data_q <= 32'h0000_0000;
    end else if (txf_pop) begin
      mac_tx_valid_q <= 1'b1;
      mac_tx_data_q <= txf_head;
    end else if (mac_tx_ready) begin
      mac_tx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) bp_q <= 1'b0;
    else bp_q <= QCW'(txq_cnt) > cfg.hwm;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_bp_level: assert property (
    ##1 bp_q == ($past(QCW'(txq_cnt)) > $past(cfg.hwm)))
    else $error("backpressure level wrong");
  a_rx_off_quiet: assert property (
    (st_q == B_IDLE && !cfg.port_control_word_zero.rx_en)
    |=> !(st_q == B_REQ && mc_burst_q.wr))
    else $error("write request while receive disabled");
  a_tx_off_quiet: assert property (
    (st_q == B_IDLE && !cfg.port_control_word_zero.tx_en)
    |=> !(st_q == B_REQ && !mc_burst_q.wr))
    else $error("read request while transmit disabled");
  a_burst_window: assert property (
    (st_q == B_REQ && b_lo <= b_hi) |-> mc_burst_q.addr >= b_lo
    && AW'(mc_burst_q.addr + AW'(mc_burst_q.cnt) - AW'(1)) <= b_hi)
    else $error("burst outside packet buffer");
  a_hdr_two: assert property (
    (st_q == B_REQ && job_q == J_HDR) |-> mc_burst_q.cnt == WCW'(HDR_WORDS)
    && rx_empty)
    else $error("header burst not final two words");
  a_setup_hold: assert property (
    st_q == B_REQ |-> bus_req_q && mc_burst_q.cnt != '0)
    else $error("burst setup incomplete");
  a_burst_stable: assert property (
    st_q == B_XFER |-> bus_req_q && $stable(mc_burst_q))
    else $error("burst setup changed during transfer");
  a_beat_count: assert property (
    st_q == B_DONE |-> beat_q == mc_burst_q.cnt && !bus_req_q)
    else $error("burst beat count wrong");
  a_lk_pulse: assert property (
    lk_req_q |=> !lk_req_q [*2])
    else $error("lookup request not a pulse");
  a_ct_only_slow: assert property (
    (st_q == B_REQ && job_q == J_RXD && !hdr_pend_q) |-> ct_mode && !FAST)
    else $error("early write without cut-through");

  c_hdr_write: cover property (st_q == B_DONE && job_q == J_HDR);
  c_tx_read: cover property (st_q == B_DONE && job_q == J_TXD);
  c_bp_rise: cover property ($rose(bp_q));
endmodule // swp_port_datapath

// ---- test/swp_mc_model.sv ----
// Behavioural memory control on the switching bus side of one port.
// Assumes registered port outputs; answers on the falling edge.
`timescale 1ns/1ps
module swp_mc_model import swp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Burst setup and write data from the port
  input wire logic bus_req_q,
  input wire swp_burst_t mc_burst_q,
  input wire logic [31:0] bus_wdata_q,
  // Grant delay, zero for prompt answers
  input wire logic [3:0] gnt_dly,
  // Answers to the port
  output logic bus_gnt,
  output logic mc_prompt,
  output logic [31:0] bus_rdata,
  // Captured write beats
  output logic cap_v,
  output logic [AW-1:0] cap_a,
  output logic [31:0] cap_d
);
  logic [31:0] mem [0:255];
  logic [1:0] st;
  logic [3:0] dl;
  logic [WCW-1:0] bt;
  logic pend;
  logic [AW-1:0] pa;

  initial begin
    bus_gnt = 1'b0;
    mc_prompt = 1'b0;
    bus_rdata = 32'h0000_0000;
    cap_v = 1'b0;
    st = 2'h0;
    pend = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    bus_gnt <= 1'b0;
    mc_prompt <= 1'b0;
    cap_v <= 1'b0;
    pend <= 1'b0;
    bus_rdata <= ~bus_rdata; // Idle bus keeps changing
    if (pend) begin
      mem[pa[7:0]] <= bus_wdata_q;
      cap_v <= 1'b1;
      cap_a <= pa;
      cap_d <= bus_wdata_q;
    end
    if (srst) st <= 2'h0;
    else case (st)
      2'h0: if (bus_req_q) begin
        st <= 2'h1;
        dl <= gnt_dly;
      end
      2'h1: if (dl == 4'h0) begin
        bus_gnt <= 1'b1;
        st <= 2'h2;
        bt <= '0;
      end else dl <= dl - 4'h1;
      2'h2: begin
        mc_prompt <= 1'b1;
        pa <= AW'(mc_burst_q.addr + AW'(bt));
        pend <= mc_burst_q.wr;
        if (!mc_burst_q.wr) bus_rdata <= mem[8'(mc_burst_q.addr + AW'(bt))];
        bt <= bt + WCW'(1);
        if (bt == mc_burst_q.cnt - WCW'(1)) st <= 2'h3;
      end
      default: if (!bus_req_q) st <= 2'h0;
    endcase
  end
endmodule // swp_mc_model

// ---- test/swp_port_datapath_tb.sv ----
// Self-checking bench of one slow port against the memory control model.
// Assumes the model file is compiled first; expected words held in queues.
`timescale 1ns/1ps
module swp_port_datapath_tb import swp_pkg::*;;
  localparam int PN = 3;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  swp_cfg_t cfg;
  logic rx_valid, lk_req_q, lk_done, lk_bcast, lk_mcast, bus_req_q, bus_gnt, mc_prompt;
  swp_rx_byte_t rx_byte;
  logic [HOST_PORT:0] lk_dst;
  swp_burst_t mc_burst_q;
  logic [31:0] bus_wdata_q, bus_rdata, mac_tx_data_q, cap_d;
  logic txq_push, mac_tx_valid_q, mac_tx_ready, bp_q, cap_v, early_w;
  logic [TXQ_W-1:0] txq_ptr;
  logic [3:0] gnt_dly;
  logic [AW-1:0] cap_a, ptr;
  int error_cnt = 0;
  int cmp_count = 0;
  int lk_cnt = 0;
  int sw_n = 0;
  logic [15:0] rnd = 16'hB3C2;
  logic [15:0] rr = 16'hB3C2;
  logic [AW-1:0] eq_a[$];
  logic [31:0] eq_d[$], eq_m[$], mq[$];
  logic [31:0] sw [0:63];

  always #50 ref_clk = ~ref_clk;

  swp_port_datapath #(.PORT_NUM(PN)) u_dut (.ref_clk(ref_clk), .srst(srst), .cfg(cfg),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .lk_req_q(lk_req_q), .lk_done(lk_done),
    .lk_dst(lk_dst), .lk_bcast(lk_bcast), .lk_mcast(lk_mcast), .bus_req_q(bus_req_q),
    .bus_gnt(bus_gnt), .mc_burst_q(mc_burst_q), .mc_prompt(mc_prompt),
    .bus_wdata_q(bus_wdata_q), .bus_rdata(bus_rdata), .txq_push(txq_push),
    .txq_ptr(txq_ptr), .mac_tx_valid_q(mac_tx_valid_q), .mac_tx_data_q(mac_tx_data_q),
    .mac_tx_ready(mac_tx_ready), .bp_q(bp_q));

  swp_mc_model u_mc (.ref_clk(ref_clk), .srst(srst), .bus_req_q(bus_req_q),
    .mc_burst_q(mc_burst_q), .bus_wdata_q(bus_wdata_q), .gnt_dly(gnt_dly),
    .bus_gnt(bus_gnt), .mc_prompt(mc_prompt), .bus_rdata(bus_rdata), .cap_v(cap_v),
    .cap_a(cap_a), .cap_d(cap_d));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [AW-1:0] adv(input logic [AW-1:0] a);
    return (a == cfg.buffer_end_address_reg) ? cfg.buffer_start_address_reg : a + AW'(1);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic settle();
    for (int i = 0; i < 4000; i++) begin
      if (eq_a.size() == 0 && mq.size() == 0) return;
      @(negedge ref_clk);
    end
    error_cnt++;
    end_of_test();
  endtask

  task automatic send(input int n, input logic crc, frm, ct, bc, mc);
    logic [31:0] w;
    logic [AW-1:0] a, b;
    logic en;
    int wc;
    en = cfg.port_control_word_zero.rx_en;
    b = ptr;
    if (b < cfg.buffer_start_address_reg || b >= cfg.buffer_end_address_reg)
      b = cfg.buffer_start_address_reg;
    a = adv(adv(b));
    wc = 0;
    early_w = 1'b0;
    cfg.port_control_word_zero.ct_en = ct;
    rnd = lfsr(rnd);
    lk_dst = {rnd[10:0], rnd};
    lk_bcast = bc;
    lk_mcast = mc;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      w = {rnd[7:0], w[31:8]};
      rx_valid = 1'b1;
      rx_byte = '{i == n - 1, crc && i == n - 1, frm && i == n - 1, rnd[7:0]};
      @(negedge ref_clk);
      rx_valid = 1'b0;
      if (i % 4 == 3 && en) begin
        eq_a.push_back(a);
        eq_d.push_back(w);
        eq_m.push_back(32'hFFFF_FFFF);
        sw[sw_n] = w;
        sw_n++;
        wc++;
        a = adv(a);
      end
      @(negedge ref_clk);
    end
    chk(early_w, ct);
    if (en) begin
      eq_a.push_back(b);
      eq_d.push_back({5'(PN), lk_dst});
      eq_m.push_back(32'hFFFF_FFFF);
      eq_a.push_back(adv(b));
      eq_d.push_back({6'h00, crc | frm | (n < 64), 1'b0, n < 64, 1'b0, frm, crc, bc, mc,
        2'b00, 4'h0, 10'(wc), 2'b00});
      eq_m.push_back(32'h03FF_FFFF);
      ptr = a;
    end
  endtask

  task automatic push_ptr(input logic [AW-1:0] p, input int k);
    txq_ptr = p;
    txq_push = 1'b1;
    @(negedge ref_clk);
    txq_push = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(bp_q, k > 2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    lk_done <= lk_req_q;
    if (lk_req_q === 1'b1) lk_cnt++;
    mac_tx_ready <= rr[0];
    rr <= lfsr(rr);
  end

  always @(posedge ref_clk) begin : mon
    logic [31:0] m;
    if (cap_v) begin
      early_w = 1'b1;
      if (eq_a.size() == 0) chk(1, 0);
      else begin
        chk(cap_a, eq_a.pop_front());
        m = eq_m.pop_front();
        chk(cap_d & m, eq_d.pop_front() & m);
      end
    end
    if (mac_tx_valid_q === 1'b1 && mac_tx_ready) begin
      if (mq.size() == 0) chk(1, 0);
      else chk(mac_tx_data_q, mq.pop_front());
    end
  end

  initial begin
    cfg = '0;
    rx_valid = 1'b0;
    rx_byte = '0;
    lk_done = 1'b0;
    lk_dst = '0;
    lk_bcast = 1'b0;
    lk_mcast = 1'b0;
    txq_push = 1'b0;
    txq_ptr = '0;
    gnt_dly = 4'h0;
    mac_tx_ready = 1'b0;
    cfg.buffer_start_address_reg = 24'h00_0010;
    cfg.buffer_end_address_reg = 24'h00_002F;
    cfg.hwm = 8'h02;
    cfg.port_control_word_zero.rx_en = 1'b1;
    ptr = cfg.buffer_start_address_reg;
    repeat (12) @(negedge ref_clk);
    chk({lk_req_q, bus_req_q, mac_tx_valid_q, bp_q}, 0);
    srst = 1'b0;
    send(64, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    gnt_dly = 4'h5;
    send(64, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    settle();
    gnt_dly = 4'h0;
    send(20, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    settle();
    chk(lk_cnt, 3);
    cfg.port_control_word_zero.rx_en = 1'b0;
    send(16, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (40) @(negedge ref_clk);
    chk(lk_cnt, 3);
    push_ptr(24'h00_0022, 1);
    push_ptr(24'h00_0014, 2);
    push_ptr(24'h00_0022, 3);
    cfg.hwm = 8'h03;
    repeat (3) @(negedge ref_clk);
    chk(bp_q, 1'b0);
    cfg.hwm = 8'h02;
    repeat (40) @(negedge ref_clk);
    chk(bp_q, 1'b1);
    chk(bus_req_q, 1'b0);
    for (int i = 16; i < 32; i++) mq.push_back(sw[i]);
    for (int i = 32; i < 37; i++) mq.push_back(sw[i]);
    for (int i = 16; i < 32; i++) mq.push_back(sw[i]);
    cfg.port_control_word_zero.tx_en = 1'b1;
    settle();
    repeat (3) @(negedge ref_clk);
    chk(bp_q, 1'b0);
    end_of_test();
  end
endmodule // swp_port_datapath_tb
